// file: include/fpg_map.vh
// Register addresses, bit layouts and reset values of the four-port I/O block
`ifndef FPG_MAP_VH
`define FPG_MAP_VH
// Register addresses on the internal CPU bus
`define FPG_ADDR_P0_DATA 16'hFF00
`define FPG_ADDR_P1_DATA 16'hFF01
`define FPG_ADDR_P2_INPUT 16'hFF02
`define FPG_ADDR_P5_DATA 16'hFF05
`define FPG_ADDR_P0_DIR 16'hFF20
`define FPG_ADDR_P1_DIR 16'hFF21
`define FPG_ADDR_P5_DIR 16'hFF25
`define FPG_ADDR_P0_PU 16'hFF30
`define FPG_ADDR_P1_PU 16'hFF31
`define FPG_ADDR_P5_PU 16'hFF35
// Implemented bit masks per port
`define FPG_MASK_P0 8'h0F
`define FPG_MASK_P1 8'hD8
`define FPG_MASK_P2 8'h0F
`define FPG_MASK_P5 8'h19
// Reset values
`define FPG_RST_DIR 8'hFF
`define FPG_RST_LATCH 8'h00
`define FPG_RST_PU 8'h00
// Alternate-function bit positions
`define FPG_BIT_SERIAL_TX 4
`define FPG_BIT_TIMER_B 0
`define FPG_BIT_TIMER_A 4
`endif

// file: logic/fpg_sync.v
// Two-stage input synchroniser, one bit per lane
`timescale 1ns/1ps
module fpg_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clock_in,
    input wire reset_in,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_q; // First stage, read only by second stage

    // Two flops in series
    always @(posedge clock_in) begin
        if (reset_in) begin
            stage1_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule

// file: logic/fpg_gpio.v
// Four-port general-purpose I/O block: registers, pin control, alternate functions
//
// Operation
// RL1 - Port 0: four bits, per-bit direction
// RL2 - Port 0 input pull-up follows select bit
// RL3 - Reset sets all direction registers to ones
// RL4 - Port 1: bits 3,4,6,7 bidirectional, pull-ups
// RL5 - Port 2: four input-only bits
// RL6 - Port 5: bits 0,3,4 bidirectional
// RL7 - Port 5 pull-up selectable per bit
// RL8 - Direction 0 drives, 1 releases pin
// RL9 - Bit and byte writes both accepted
// RL10 - Unimplemented direction bits read as one
// RL11 - Software sets direction/latch for alternate functions
// RL12 - Read gives pin in input, latch in output
// RL13 - Write to input bit updates latch only
// RL14 - No pull-up on output or alternate output
// RL15 - Reset clears output latches to zero
// RL16 - Pin inputs pass two-stage synchroniser
// RL17 - Alternate output combined with latch drives pin
`timescale 1ns/1ps
`include "fpg_map.vh"
module fpg_gpio (
    // Clock and reset
    input wire clock_in,
    input wire reset_in,
    // CPU register port
    input wire [15:0] addr_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] wdata_in,
    output reg [7:0] rdata_out,
    // Port pin inputs
    input wire [7:0] port0_pin_in,
    input wire [7:0] port1_pin_in,
    input wire [7:0] port2_pin_in,
    input wire [7:0] port5_pin_in,
    // Alternate-function outputs from peripherals
    input wire serial_transmit_in,
    input wire serial_tx_active_in,
    input wire timer_b_output_in,
    input wire timer_b_active_in,
    input wire timer_a_output_in,
    input wire timer_a_active_in,
    // Pin drive, enable and pull-up
    output reg [7:0] port0_pin_out,
    output reg [7:0] port0_oe_out,
    output reg [7:0] port0_pullup_out,
    output reg [7:0] port1_pin_out,
    output reg [7:0] port1_oe_out,
    output reg [7:0] port1_pullup_out,
    output reg [7:0] port5_pin_out,
    output reg [7:0] port5_oe_out,
    output reg [7:0] port5_pullup_out,
    // Synchronised levels to alternate-function inputs
    output reg [7:0] port0_sync_out,
    output reg [7:0] port1_sync_out,
    output reg [7:0] port2_sync_out,
    output reg [7:0] port5_sync_out
);
    // Control registers
    reg [7:0] p0_dir_q, p1_dir_q, p5_dir_q;
    reg [7:0] p0_lat_q, p1_lat_q, p5_lat_q;
    reg [7:0] p0_pu_q, p1_pu_q, p5_pu_q;
    // Synchronised pin levels
    wire [7:0] s0, s1, s2, s5;
    // Combinational next values
    reg [7:0] rd_d;
    reg [7:0] p0_drv_d, p1_drv_d, p5_drv_d;
    reg [7:0] alt_out1, alt_out5; // Alternate-function output masks

    // Pin input synchronisers, all ports at once
    fpg_sync #(.WIDTH(32)) u_sync ( // [RL16]
        .clock_in(clock_in),
        .reset_in(reset_in),
        .async_in({port5_pin_in, port2_pin_in, port1_pin_in, port0_pin_in}),
        .sync_out({s5, s2, s1, s0})
    );

    // Register writes, byte-wide; bit writes arrive as read-modify-write bytes
    always @(posedge clock_in) begin
        if (reset_in) begin
            p0_dir_q <= `FPG_RST_DIR; // [RL3]
            p1_dir_q <= `FPG_RST_DIR; // [RL3]
            p5_dir_q <= `FPG_RST_DIR; // [RL3]
            p0_lat_q <= `FPG_RST_LATCH; // [RL15]
            p1_lat_q <= `FPG_RST_LATCH; // [RL15]
            p5_lat_q <= `FPG_RST_LATCH; // [RL15]
            p0_pu_q <= `FPG_RST_PU;
            p1_pu_q <= `FPG_RST_PU;
            p5_pu_q <= `FPG_RST_PU;
        end else if (wr_in) begin // [RL9]
            case (addr_in)
                // Unimplemented direction bits forced to one
                `FPG_ADDR_P0_DIR: p0_dir_q <= wdata_in | ~`FPG_MASK_P0; // [RL1] [RL10]
                `FPG_ADDR_P1_DIR: p1_dir_q <= wdata_in | ~`FPG_MASK_P1; // [RL4] [RL10]
                `FPG_ADDR_P5_DIR: p5_dir_q <= wdata_in | ~`FPG_MASK_P5; // [RL6] [RL10]
                // Latch written regardless of direction
                `FPG_ADDR_P0_DATA: p0_lat_q <= wdata_in & `FPG_MASK_P0; // [RL13]
                `FPG_ADDR_P1_DATA: p1_lat_q <= wdata_in & `FPG_MASK_P1; // [RL13]
                `FPG_ADDR_P5_DATA: p5_lat_q <= wdata_in & `FPG_MASK_P5; // [RL13]
                `FPG_ADDR_P0_PU: p0_pu_q <= wdata_in & `FPG_MASK_P0; // [RL2]
                `FPG_ADDR_P1_PU: p1_pu_q <= wdata_in & `FPG_MASK_P1; // [RL4]
                `FPG_ADDR_P5_PU: p5_pu_q <= wdata_in & `FPG_MASK_P5; // [RL7]
                // Port 2 and unmapped addresses ignore writes
                default: begin
                end
            endcase
        end
    end

    // Read multiplexer: pin in input mode, latch in output mode
    always @* begin
        case (addr_in)
            `FPG_ADDR_P0_DATA: rd_d = ((s0 & p0_dir_q) | (p0_lat_q & ~p0_dir_q)) & `FPG_MASK_P0; // [RL12]
            `FPG_ADDR_P1_DATA: rd_d = ((s1 & p1_dir_q) | (p1_lat_q & ~p1_dir_q)) & `FPG_MASK_P1; // [RL12]
            `FPG_ADDR_P2_INPUT: rd_d = s2 & `FPG_MASK_P2; // [RL5]
            `FPG_ADDR_P5_DATA: rd_d = ((s5 & p5_dir_q) | (p5_lat_q & ~p5_dir_q)) & `FPG_MASK_P5; // [RL12]
            `FPG_ADDR_P0_DIR: rd_d = p0_dir_q;
            `FPG_ADDR_P1_DIR: rd_d = p1_dir_q;
            `FPG_ADDR_P5_DIR: rd_d = p5_dir_q;
            `FPG_ADDR_P0_PU: rd_d = p0_pu_q;
            `FPG_ADDR_P1_PU: rd_d = p1_pu_q;
            `FPG_ADDR_P5_PU: rd_d = p5_pu_q;
            // Unmapped reads return zero
            default: rd_d = 8'h00;
        endcase
    end

    // Pin drive values with alternate outputs merged
    always @* begin
        alt_out1 = 8'h00;
        alt_out5 = 8'h00;
        alt_out1[`FPG_BIT_SERIAL_TX] = serial_tx_active_in;
        alt_out5[`FPG_BIT_TIMER_B] = timer_b_active_in;
        alt_out5[`FPG_BIT_TIMER_A] = timer_a_active_in;
        p0_drv_d = p0_lat_q;
        p1_drv_d = p1_lat_q;
        p5_drv_d = p5_lat_q;
        // Serial transmit idles high, so latch 1 ANDed with it
        if (serial_tx_active_in) begin
            p1_drv_d[`FPG_BIT_SERIAL_TX] = p1_lat_q[`FPG_BIT_SERIAL_TX] & serial_transmit_in; // [RL17] [RL11]
        end
        // Timer outputs ORed with latch that software holds at 0
        if (timer_b_active_in) begin
            p5_drv_d[`FPG_BIT_TIMER_B] = p5_lat_q[`FPG_BIT_TIMER_B] | timer_b_output_in; // [RL17] [RL11]
        end
        if (timer_a_active_in) begin
            p5_drv_d[`FPG_BIT_TIMER_A] = p5_lat_q[`FPG_BIT_TIMER_A] | timer_a_output_in; // [RL17] [RL11]
        end
    end

    // Registered outputs
    always @(posedge clock_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
            port0_pin_out <= 8'h00;
            port1_pin_out <= 8'h00;
            port5_pin_out <= 8'h00;
            port0_oe_out <= 8'h00;
            port1_oe_out <= 8'h00;
            port5_oe_out <= 8'h00;
            port0_pullup_out <= 8'h00;
            port1_pullup_out <= 8'h00;
            port5_pullup_out <= 8'h00;
            port0_sync_out <= 8'h00;
            port1_sync_out <= 8'h00;
            port2_sync_out <= 8'h00;
            port5_sync_out <= 8'h00;
        end else begin
            // Read data captured when read strobe is high
            if (rd_in) begin
                rdata_out <= rd_d;
            end
            port0_pin_out <= p0_drv_d & `FPG_MASK_P0;
            port1_pin_out <= p1_drv_d & `FPG_MASK_P1;
            port5_pin_out <= p5_drv_d & `FPG_MASK_P5;
            // Buffer on when direction bit is 0
            port0_oe_out <= ~p0_dir_q & `FPG_MASK_P0; // [RL8] [RL1]
            port1_oe_out <= ~p1_dir_q & `FPG_MASK_P1; // [RL8] [RL4]
            port5_oe_out <= ~p5_dir_q & `FPG_MASK_P5; // [RL8] [RL6]
            // Pull-up only in input mode and not on active alternate output
            port0_pullup_out <= p0_pu_q & p0_dir_q & `FPG_MASK_P0; // [RL2] [RL14]
            port1_pullup_out <= p1_pu_q & p1_dir_q & ~alt_out1 & `FPG_MASK_P1; // [RL14]
            port5_pullup_out <= p5_pu_q & p5_dir_q & ~alt_out5 & `FPG_MASK_P5; // [RL7] [RL14]
            port0_sync_out <= s0 & `FPG_MASK_P0; // [RL16]
            port1_sync_out <= s1 & `FPG_MASK_P1;
            port2_sync_out <= s2 & `FPG_MASK_P2; // [RL5]
            port5_sync_out <= s5 & `FPG_MASK_P5;
        end
    end
endmodule

// file: sim/fpg_pad_model.sv
// Pin-side model: resolves each pad from drive, enable, pull-up and a far-side level
`timescale 1ns/1ps
module fpg_pad_model (
    // Design side
    input wire [7:0] drive_in,
    input wire [7:0] oe_in,
    input wire [7:0] pullup_in,
    // Far side
    input wire [7:0] ext_in,
    output wire [7:0] level_out
);
    // Driven bits follow the drive input, released bits read the pull-up or far side
    assign level_out = (oe_in & drive_in) | (~oe_in & (pullup_in | ext_in));
endmodule

// file: sim/fpg_gpio_asserts.sv
// Port-level assertions for the four-port I/O block
`timescale 1ns/1ps
`include "fpg_map.vh"
module fpg_gpio_asserts (
    // Clock, reset and CPU port
    input wire clock_in,
    input wire reset_in,
    input wire [15:0] addr_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] wdata_in,
    input wire [7:0] rdata_out,
    // Pins
    input wire [7:0] port2_pin_in,
    input wire [7:0] port2_sync_out,
    input wire [7:0] port0_oe_out,
    input wire [7:0] port1_oe_out,
    input wire [7:0] port5_oe_out,
    input wire [7:0] port5_pullup_out,
    input wire [7:0] port0_pin_out,
    input wire [7:0] port5_pin_out
);
    // One clock domain for every check
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    // A byte write to the port 0 direction register
    sequence p0_dir_wr_s;
        wr_in && addr_in == `FPG_ADDR_P0_DIR;
    endsequence
    reset_dir_a: assert property (disable iff (1'h0) reset_in |=> (port0_oe_out | port1_oe_out | port5_oe_out) == 8'h00)
        else $error("pin enabled after reset");
    latch_reset_a: assert property (disable iff (1'h0) reset_in |=> (port0_pin_out | port5_pin_out) == 8'h00)
        else $error("latch not cleared by reset");
    p0_dir_a: assert property (p0_dir_wr_s |=> ##1 port0_oe_out == (~$past(wdata_in, 2) & 8'h0F))
        else $error("port 0 enable does not follow direction write");
    dir_read_a: assert property (rd_in && addr_in == `FPG_ADDR_P0_DIR |=> rdata_out[7:4] == 4'hF)
        else $error("absent direction bits not read as one");
    pu_excl_a: assert property ((port5_pullup_out & port5_oe_out) == 8'h00)
        else $error("pull-up on an output bit");
    oe_mask_a: assert property ((port1_oe_out & 8'h27) == 8'h00 && (port5_oe_out & 8'hE6) == 8'h00)
        else $error("absent pin enabled");
    sync_in_a: assert property ((!reset_in && $stable(port2_pin_in))[*4] |-> port2_sync_out == (port2_pin_in & 8'h0F))
        else $error("synchronised level wrong");
    unmapped_a: assert property (rd_in && addr_in == 16'hFF10 |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind fpg_gpio fpg_gpio_asserts u_chk (.clock_in, .reset_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
    .port2_pin_in, .port2_sync_out, .port0_oe_out, .port1_oe_out, .port5_oe_out, .port5_pullup_out, .port0_pin_out,
    .port5_pin_out);

// file: sim/tb.sv
// Self-checking bench for the four-port I/O block
`timescale 1ns/1ps
`include "fpg_map.vh"
module tb;
    // Design inputs, far-side levels and peripheral outputs
    reg clock_in = 1'h0, reset_in = 1'h1, wr_in = 1'h0, rd_in = 1'h0;
    reg serial_transmit_in = 1'h0, serial_tx_active_in = 1'h0, timer_b_output_in = 1'h0;
    reg timer_b_active_in = 1'h0, timer_a_output_in = 1'h0, timer_a_active_in = 1'h0;
    reg [15:0] addr_in = 16'h0000;
    reg [7:0] wdata_in = 8'h00, port2_pin_in = 8'h00, e0 = 8'h00, e1 = 8'h00, e5 = 8'h00;
    // Design outputs and resolved pads
    wire [7:0] rdata_out, port0_pin_out, port0_oe_out, port0_pullup_out, port1_pin_out, port1_oe_out;
    wire [7:0] port1_pullup_out, port5_pin_out, port5_oe_out, port5_pullup_out;
    wire [7:0] port0_pin_in, port1_pin_in, port5_pin_in;
    wire [7:0] port0_sync_out, port1_sync_out, port2_sync_out, port5_sync_out;
    integer failures = 0, n_checks = 0;
    always #25 clock_in = ~clock_in;
    fpg_gpio uut (.clock_in, .reset_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out, .port0_pin_in,
        .port1_pin_in, .port2_pin_in, .port5_pin_in, .serial_transmit_in, .serial_tx_active_in, .timer_b_output_in,
        .timer_b_active_in, .timer_a_output_in, .timer_a_active_in, .port0_pin_out, .port0_oe_out,
        .port0_pullup_out, .port1_pin_out, .port1_oe_out, .port1_pullup_out, .port5_pin_out, .port5_oe_out,
        .port5_pullup_out, .port0_sync_out, .port1_sync_out, .port2_sync_out, .port5_sync_out);
    fpg_pad_model pad0 (.drive_in(port0_pin_out), .oe_in(port0_oe_out), .pullup_in(port0_pullup_out),
        .ext_in(e0), .level_out(port0_pin_in));
    fpg_pad_model pad1 (.drive_in(port1_pin_out), .oe_in(port1_oe_out), .pullup_in(port1_pullup_out),
        .ext_in(e1), .level_out(port1_pin_in));
    fpg_pad_model pad5 (.drive_in(port5_pin_out), .oe_in(port5_oe_out), .pullup_in(port5_pullup_out),
        .ext_in(e5), .level_out(port5_pin_in));
    task idle(input integer n);
        repeat (n) @(negedge clock_in);
    endtask
    task cmp(input [31:0] name, input [7:0] exp, input [7:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("MISMATCH %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    // One byte write, strobe high for one edge
    task wr_reg(input [15:0] a, input [7:0] d);
        begin
            idle(1);
            addr_in = a;
            wdata_in = d;
            wr_in = 1'h1;
            idle(1);
            wr_in = 1'h0;
        end
    endtask
    // One byte read, compared once the answer has landed
    task rd_reg(input [15:0] a, input [7:0] exp);
        begin
            idle(1);
            addr_in = a;
            rd_in = 1'h1;
            idle(1);
            rd_in = 1'h0;
            idle(1);
            cmp("rd", exp, rdata_out);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, failures);
            if (failures == 0 && n_checks > 0) $display("Finished cleanly");
            else $display("Finished with errors");
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        idle(2);
        reset_in = 1'h0;
        rd_reg(`FPG_ADDR_P1_DIR, 8'hFF);
        rd_reg(`FPG_ADDR_P0_DATA, 8'h00);
        wr_reg(`FPG_ADDR_P0_DIR, 8'h00);
        wr_reg(`FPG_ADDR_P0_DATA, 8'h05);
        rd_reg(`FPG_ADDR_P0_DIR, 8'hF0);
        rd_reg(`FPG_ADDR_P0_DATA, 8'h05);
        cmp("oe0", 8'h0F, port0_oe_out);
        wr_reg(`FPG_ADDR_P1_DATA, 8'hD8);
        rd_reg(`FPG_ADDR_P1_DATA, 8'h00);
        cmp("oe1", 8'h00, port1_oe_out);
        wr_reg(`FPG_ADDR_P1_DIR, 8'h00);
        rd_reg(`FPG_ADDR_P1_DATA, 8'hD8);
        rd_reg(`FPG_ADDR_P1_DIR, 8'h27);
        serial_tx_active_in = 1'h1;
        idle(3);
        cmp("pin1", 8'hC8, port1_pin_out);
        wr_reg(`FPG_ADDR_P5_PU, 8'hFF);
        idle(5);
        cmp("pu5", 8'h19, port5_pullup_out);
        rd_reg(`FPG_ADDR_P5_DATA, 8'h19);
        wr_reg(`FPG_ADDR_P5_DIR, 8'h00);
        timer_a_active_in = 1'h1;
        timer_a_output_in = 1'h1;
        timer_b_active_in = 1'h1;
        timer_b_output_in = 1'h1;
        idle(3);
        cmp("pu5", 8'h00, port5_pullup_out);
        cmp("pin5", 8'h11, port5_pin_out);
        port2_pin_in = 8'hFA;
        wr_reg(`FPG_ADDR_P2_INPUT, 8'h05);
        rd_reg(`FPG_ADDR_P2_INPUT, 8'h0A);
        cmp("sy0", 8'h05, port0_sync_out);
        cmp("sy1", 8'hC8, port1_sync_out);
        cmp("sy2", 8'h0A, port2_sync_out);
        cmp("sy5", 8'h11, port5_sync_out);
        rd_reg(16'hFF10, 8'h00);
        wr_reg(`FPG_ADDR_P0_DIR, 8'hFF);
        wr_reg(`FPG_ADDR_P0_PU, 8'h0A);
        idle(2);
        cmp("pu0", 8'h0A, port0_pullup_out);
        reset_in = 1'h1;
        idle(2);
        reset_in = 1'h0;
        cmp("pin5", 8'h00, port5_pin_out);
        rd_reg(`FPG_ADDR_P5_DIR, 8'hFF);
        wr_reg(`FPG_ADDR_P1_PU, 8'hFF);
        idle(2);
        cmp("pu1", 8'hC8, port1_pullup_out);
        close_out;
    end
    // Watchdog, far beyond the roughly 72 cycles the sequence needs
    initial begin
        #100000;
        failures = failures + 1;
        close_out;
    end
endmodule
